//--- common/tsc_pkg.sv
package tsc_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] CST_OFF  = 8'h00;
	localparam logic [7:0] ADJ_OFF  = 8'h04;
	localparam logic [7:0] IST_OFF  = 8'h08;
	localparam logic [7:0] IMSK_OFF = 8'h0c;
	localparam logic [7:0] LIM_OFF  = 8'h10;
	localparam logic [7:0] PWD_OFF  = 8'h20;
	localparam int         NLIM     = 4;
	localparam logic [1:0] LIM_SD   = 2'h0;
	localparam logic [1:0] LIM_LOOP = 2'h1;
	localparam logic [1:0] LIM_TMR  = 2'h2;
	localparam logic [1:0] LIM_LIT  = 2'h3;
	// ==========================================
	// Control and status field positions
	localparam int CST_EN   = 15;
	localparam int CST_SIDL = 13;
	localparam int CST_TOGL = 12;
	localparam int CST_SWT  = 10;
	localparam int CST_SSEN = 9;
	localparam int CST_VIS  = 8;
	localparam int CST_RUN  = 7;
	localparam int CST_WDTO = 6;
	localparam int ITM_LSB  = 0;
	localparam int ITM_W    = 2;
	localparam logic [15:0] CST_RMASK = 16'hb7c3;
	localparam logic [15:0] CST_RST   = 16'h0000;
	localparam logic [15:0] ADJ_RST   = 16'h0000;
	// ==========================================
	// Interrupt status bits
	localparam int IRQ_W    = 2;
	localparam int IRQ_WDTO = 0;
	localparam int IRQ_SWT  = 1;
	localparam int PWD_W    = 4;
endpackage

//--- core/tsc_ctrl.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module tsc_ctrl (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        idle_mode,
	input  wire logic        trigger_output_command,
	input  wire logic        control_step_command,
	input  wire logic        wait_high_command,
	input  wire logic        wait_low_command,
	input  wire logic        add_adjust_command,
	input  wire logic [1:0]  add_select,
	input  wire logic        watchdog_expire,
	input  wire logic [15:0] step_delay_counter,
	input  wire logic [15:0] loop_counter,
	input  wire logic [15:0] sequencer_timer,
	output logic             sequencer_active,
	output logic             single_step_mode,
	output logic             soft_trigger_taken,
	output logic             trigger_out,
	output logic [1:0]       wait_trigger_mode,
	output logic [15:0]      step_delay_limit,
	output logic [15:0]      loop_counter_limit,
	output logic [15:0]      timer_limit,
	output logic [15:0]      literal_value,
	output logic             irq
);
	// ==========================================
	// Bus decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	localparam int IRQ_W = tsc_pkg::IRQ_W;

	logic        access;
	logic        wr;
	logic        rd;
	logic [15:0] cst_reg;
	logic [15:0] adj_reg;
	logic [IRQ_W-1:0] ist_reg;
	logic [IRQ_W-1:0] imsk_reg;
	logic [tsc_pkg::PWD_W-1:0] pwd_reg;
	logic [15:0] lim_reg [tsc_pkg::NLIM];
	logic [tsc_pkg::PWD_W-1:0] pulse_cnt_reg;
	logic        en_run;
	logic        active;
	logic        swt_use;
	logic        mapped;
	logic        lim_hit;
	logic [1:0]  lim_idx;
	logic [15:0] live_val;
	logic [31:0] rdata_next;

	// One wait state: pready rises on the second access cycle
	assign access  = psel && penable && pready;
	assign wr      = access && pwrite;
	assign rd      = access && !pwrite;
	assign lim_idx = paddr[3:2];
	assign lim_hit = (paddr[7:4] == tsc_pkg::LIM_OFF[7:4]) && (paddr[1:0] == 2'h0);
	assign mapped  = hit(paddr, tsc_pkg::CST_OFF) || hit(paddr, tsc_pkg::ADJ_OFF)
		|| hit(paddr, tsc_pkg::IST_OFF) || hit(paddr, tsc_pkg::IMSK_OFF)
		|| hit(paddr, tsc_pkg::PWD_OFF) || lim_hit;

	assign en_run  = cst_reg[tsc_pkg::CST_EN] && cst_reg[tsc_pkg::CST_RUN];
	assign active  = en_run && !(idle_mode && cst_reg[tsc_pkg::CST_SIDL]);
	assign swt_use = active && control_step_command && cst_reg[tsc_pkg::CST_SWT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// ==========================================
	// Control and status
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cst_reg <= tsc_pkg::CST_RST;
		end else begin
			if (wr && hit(paddr, tsc_pkg::CST_OFF)) begin
				cst_reg <= pwdata[15:0] & tsc_pkg::CST_RMASK;
				cst_reg[tsc_pkg::CST_SWT] <= cst_reg[tsc_pkg::CST_SWT]
					|| pwdata[tsc_pkg::CST_SWT];
				// Software may only clear the flag; a new expiry wins
				cst_reg[tsc_pkg::CST_WDTO] <= watchdog_expire
					|| (cst_reg[tsc_pkg::CST_WDTO] && pwdata[tsc_pkg::CST_WDTO]);
			end else begin
				if (watchdog_expire) begin
					cst_reg[tsc_pkg::CST_WDTO] <= 1'b1;
				end
				if (swt_use) begin
					cst_reg[tsc_pkg::CST_SWT] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// Adjust and limit registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			adj_reg <= tsc_pkg::ADJ_RST;
		end else if (wr && hit(paddr, tsc_pkg::ADJ_OFF) && !en_run) begin
			adj_reg <= pwdata[15:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < tsc_pkg::NLIM; gi++) begin : g_lim
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					lim_reg[gi] <= 16'h0000;
				end else if (active && add_adjust_command && add_select == 2'(gi)) begin
					lim_reg[gi] <= lim_reg[gi] + adj_reg;
				end else if (wr && lim_hit && lim_idx == 2'(gi)) begin
					lim_reg[gi] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwd_reg  <= '0;
			imsk_reg <= '0;
		end else begin
			if (wr && hit(paddr, tsc_pkg::PWD_OFF)) begin
				pwd_reg <= pwdata[tsc_pkg::PWD_W-1:0];
			end
			if (wr && hit(paddr, tsc_pkg::IMSK_OFF)) begin
				imsk_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// ==========================================
	// Interrupt status, cleared by read; events win
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ist_reg <= '0;
			irq     <= 1'b0;
		end else begin
			ist_reg <= ((rd && hit(paddr, tsc_pkg::IST_OFF)) ? '0 : ist_reg)
				| {swt_use, watchdog_expire};
			irq     <= |(ist_reg & imsk_reg);
		end
	end

	// ==========================================
	// Read data
	always_comb begin
		unique case (lim_idx)
			tsc_pkg::LIM_SD:   live_val = step_delay_counter;
			tsc_pkg::LIM_LOOP: live_val = loop_counter;
			tsc_pkg::LIM_TMR:  live_val = sequencer_timer;
			tsc_pkg::LIM_LIT:  live_val = lim_reg[tsc_pkg::LIM_LIT];
		endcase
		rdata_next = 32'h0000_0000;
		if (hit(paddr, tsc_pkg::CST_OFF)) begin
			rdata_next[15:0] = cst_reg & tsc_pkg::CST_RMASK;
		end else if (hit(paddr, tsc_pkg::ADJ_OFF)) begin
			rdata_next[15:0] = adj_reg;
		end else if (hit(paddr, tsc_pkg::IST_OFF)) begin
			rdata_next[IRQ_W-1:0] = ist_reg;
		end else if (hit(paddr, tsc_pkg::IMSK_OFF)) begin
			rdata_next[IRQ_W-1:0] = imsk_reg;
		end else if (hit(paddr, tsc_pkg::PWD_OFF)) begin
			rdata_next[tsc_pkg::PWD_W-1:0] = pwd_reg;
		end else if (lim_hit) begin
			rdata_next[15:0] = cst_reg[tsc_pkg::CST_VIS] ? live_val
				: lim_reg[lim_idx];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready && !pwrite) begin
			prdata <= rdata_next;
		end
	end

	// ==========================================
	// Trigger output
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			trigger_out   <= 1'b0;
			pulse_cnt_reg <= '0;
		end else if (active && trigger_output_command) begin
			if (cst_reg[tsc_pkg::CST_TOGL]) begin
				trigger_out <= !trigger_out;
			end else begin
				trigger_out   <= 1'b1;
				pulse_cnt_reg <= pwd_reg;
			end
		end else if (!cst_reg[tsc_pkg::CST_TOGL] && trigger_out) begin
			// Pulse lasts pulse width plus one cycles
			if (pulse_cnt_reg == '0) begin
				trigger_out <= 1'b0;
			end else begin
				pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
			end
		end
	end

	// ==========================================
	// Mode outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sequencer_active   <= 1'b0;
			single_step_mode   <= 1'b0;
			soft_trigger_taken <= 1'b0;
			wait_trigger_mode  <= 2'h0;
		end else begin
			sequencer_active   <= active;
			single_step_mode   <= cst_reg[tsc_pkg::CST_EN] && cst_reg[tsc_pkg::CST_SSEN];
			soft_trigger_taken <= swt_use;
			if (wait_high_command || wait_low_command) begin
				wait_trigger_mode <= cst_reg[tsc_pkg::ITM_LSB +: tsc_pkg::ITM_W];
			end
		end
	end

	assign step_delay_limit   = lim_reg[tsc_pkg::LIM_SD];
	assign loop_counter_limit = lim_reg[tsc_pkg::LIM_LOOP];
	assign timer_limit        = lim_reg[tsc_pkg::LIM_TMR];
	assign literal_value      = lim_reg[tsc_pkg::LIM_LIT];
endmodule

//--- test/tsc_ctrl_props.sv
`timescale 1ns/1ps
// ==========================
// Port checker
module tsc_ctrl_props (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        trigger_output_command,
	input wire logic        control_step_command,
	input wire logic        wait_high_command,
	input wire logic        wait_low_command,
	input wire logic        sequencer_active,
	input wire logic        soft_trigger_taken,
	input wire logic        trigger_out,
	input wire logic [1:0]  wait_trigger_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	ack_wait_a: assert property ($rose(penable) && psel |=> pready)
		else $error("ready late");
	ack_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	err_ack_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	ctrl_zero_a: assert property (pready && !pwrite && paddr == tsc_pkg::CST_OFF
		|-> (prdata & ~{16'h0000, tsc_pkg::CST_RMASK}) == 32'h0)
		else $error("unused control bits set");
	trig_cause_a: assert property ($rose(trigger_out)
		|-> $past(trigger_output_command && sequencer_active))
		else $error("trigger rose without command");
	trig_off_a: assert property (trigger_output_command && !sequencer_active && !trigger_out
		|=> !trigger_out)
		else $error("trigger while stopped");
	soft_cause_a: assert property (soft_trigger_taken
		|-> $past(control_step_command && sequencer_active))
		else $error("soft trigger without step");
	wait_cause_a: assert property ($changed(wait_trigger_mode)
		|-> $past(wait_high_command || wait_low_command))
		else $error("wait mode changed alone");
	cover property ($fell(trigger_out));
	cover property (soft_trigger_taken);
	cover property (pslverr);
endmodule
bind tsc_ctrl tsc_ctrl_props u_props (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .trigger_output_command, .control_step_command, .wait_high_command,
	.wait_low_command, .sequencer_active, .soft_trigger_taken, .trigger_out, .wait_trigger_mode);

//--- test/trigger_sequencer_control_tb.sv
`timescale 1ns/1ps
// ==========================
// Sequencer control bench
module trigger_sequencer_control_tb;
	localparam logic [7:0] CST = tsc_pkg::CST_OFF;
	localparam logic [7:0] ADJ = tsc_pkg::ADJ_OFF;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr, idle_mode, irq, perr;
	logic        sequencer_active, single_step_mode, soft_trigger_taken, trigger_out;
	logic [1:0]  wait_trigger_mode;
	logic [5:0]  cmd;
	logic [7:0]  paddr;
	logic [15:0] literal_value;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors = 0, total_checks = 0, cyc = 0;
	tsc_ctrl dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .idle_mode, .trigger_output_command(cmd[0]), .control_step_command(cmd[1]),
		.wait_high_command(cmd[2]), .wait_low_command(cmd[3]), .add_adjust_command(cmd[4]),
		.add_select(tsc_pkg::LIM_LIT), .watchdog_expire(cmd[5]), .step_delay_counter(16'h7777),
		.loop_counter(16'h0000), .sequencer_timer(16'h0000), .sequencer_active,
		.single_step_mode, .soft_trigger_taken, .trigger_out, .wait_trigger_mode,
		.step_delay_limit(), .loop_counter_limit(), .timer_limit(), .literal_value, .irq);
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	// Runs take under two hundred cycles; the ceiling of 3000 leaves ample margin
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 16'h0000);
		chk(rd, e);
	endtask
	// Command pulse of one cycle; ends where outputs have settled
	task automatic fire(input int i);
		@(posedge clock);
		cmd[i] <= 1'h1;
		@(posedge clock);
		cmd[i] <= 1'h0;
		@(negedge clock);
	endtask
	task automatic t_regs;
		rdc(CST, 32'h0);
		rdc(ADJ, 32'h0);
		wr(ADJ, 16'ha55a);
		rdc(ADJ, 32'ha55a);
		wr(tsc_pkg::LIM_OFF, 16'h0042);
		rdc(tsc_pkg::LIM_OFF, 32'h42);
		wr(tsc_pkg::LIM_OFF + 8'h0c, 16'h0001);
		rdc(8'h24, 32'h0);
		chk(perr, 1'h1);
	endtask
	task automatic t_run;
		wr(CST, 16'hffbf);
		rdc(CST, 32'hb783);
		repeat (2) @(negedge clock);
		chk(sequencer_active, 1'h1);
		chk(single_step_mode, 1'h1);
		wr(ADJ, 16'h1234);
		rdc(ADJ, 32'ha55a);
		rdc(tsc_pkg::LIM_OFF, 32'h7777);
		fire(1);
		chk(soft_trigger_taken, 1'h1);
		rdc(CST, 32'hb383);
		fire(1);
		chk(soft_trigger_taken, 1'h0);
		fire(2);
		chk(wait_trigger_mode, 2'h3);
	endtask
	task automatic t_trig;
		int n;
		fire(0);
		chk(trigger_out, 1'h1);
		fire(0);
		chk(trigger_out, 1'h0);
		wr(CST, 16'hefbf);
		wr(tsc_pkg::PWD_OFF, 16'h0002);
		fire(0);
		n = 0;
		repeat (4) begin
			n += trigger_out;
			@(negedge clock);
		end
		chk(n, 32'h3);
		fire(4);
		chk(literal_value, 16'ha55b);
	endtask
	task automatic t_stop;
		wr(CST, 16'ha081);
		idle_mode <= 1'h1;
		repeat (2) @(negedge clock);
		chk(sequencer_active, 1'h0);
		fire(0);
		chk(trigger_out, 1'h0);
		fire(3);
		chk(wait_trigger_mode, 2'h1);
		wr(CST, 16'h8080);
		repeat (2) @(negedge clock);
		chk(sequencer_active, 1'h1);
		wr(CST, 16'h8000);
		idle_mode <= 1'h0;
		repeat (2) @(negedge clock);
		chk(sequencer_active, 1'h0);
		wr(CST, 16'h0280);
		repeat (2) @(negedge clock);
		chk({sequencer_active, single_step_mode}, 2'h0);
		wr(CST, 16'h0000);
	endtask
	task automatic t_wdto;
		fire(5);
		repeat (2) @(negedge clock);
		chk(irq, 1'h0);
		wr(tsc_pkg::IMSK_OFF, 16'h0001);
		repeat (2) @(negedge clock);
		chk(irq, 1'h1);
		rdc(CST, 32'h440);
		rdc(tsc_pkg::IST_OFF, 32'h3);
		rdc(tsc_pkg::IST_OFF, 32'h0);
		repeat (2) @(negedge clock);
		chk(irq, 1'h0);
		rdc(CST, 32'h440);
		wr(CST, 16'h0000);
		rdc(CST, 32'h400);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{rstn, psel, penable, pwrite, idle_mode, cmd, paddr, pwdata} = '0;
		repeat (2) @(posedge clock);
		rstn <= 1'h1;
		t_regs();
		t_run();
		t_trig();
		t_stop();
		t_wdto();
		wrap_up();
	end
endmodule
